// >>> isatc_pkg.sv
package isatc_pkg;

    // ****************************************
    // window decode
    // ****************************************
    localparam logic [9:0] BASE_DEFAULT = 10'h08C;
    localparam logic [5:0] OFF_PTR      = 6'h00;
    localparam logic [5:0] OFF_DATA     = 6'h02;
    localparam logic [5:0] OFF_CTL      = 6'h04;
    localparam logic [5:0] OFF_IEN      = 6'h06;
    localparam logic [5:0] OFF_IFL      = 6'h08;
    localparam logic [5:0] OFF_AT0      = 6'h0A;
    localparam logic [5:0] OFF_AT1      = 6'h0C;
    localparam logic [5:0] OFF_AT2      = 6'h0E;
    localparam logic [5:0] OFF_AT3      = 6'h10;
    localparam logic [5:0] OFF_PHL      = 6'h12;
    localparam logic [5:0] OFF_PHH      = 6'h14;
    localparam logic [5:0] OFF_UPL      = 6'h16;
    localparam logic [5:0] OFF_UPH      = 6'h18;
    localparam logic [5:0] OFF_LAT      = 6'h1A;

    // ****************************************
    // register fields and reset values
    // ****************************************
    localparam int C_GO      = 1;
    localparam int C_SNRST   = 9;
    localparam int C_SNCLK   = 10;
    localparam int C_SELF    = 12;
    localparam int C_XCLR    = 13;
    localparam int I_MS      = 0;
    localparam int I_SEC     = 1;
    localparam int I_SELF    = 2;
    localparam int I_PLL     = 3;
    localparam int I_EXT     = 4;
    localparam int I_TV      = 5;
    localparam int I_QMS     = 6;
    localparam int I_MASTER  = 15;
    localparam logic [15:0] CTL_STORE = 16'h01FD;
    localparam logic [15:0] IEN_STORE = 16'h807F;
    localparam logic [15:0] CTL_RST   = 16'h0000;
    localparam logic [15:0] IEN_RST   = 16'h0000;
    localparam logic [7:0]  PTR_RST   = 8'h00;

    // ****************************************
    // internal memory map
    // ****************************************
    localparam logic [7:0] MEM_CFG = 8'h40;
    localparam logic [7:0] MEM_SUP = 8'h80;
    localparam logic [7:0] MEM_END = 8'hC0;

    // ****************************************
    // timing
    // ****************************************
    localparam int REF_LOSS_NS   = 1000;
    localparam int CLK_PERIOD_NS = 8;
    localparam int REF_LOSS_I    = (REF_LOSS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam logic [7:0] REF_LOSS_CYC = 8'(REF_LOSS_I);

    // ****************************************
    // types
    // ****************************************
    typedef struct packed {
        logic [15:0] addr;
        logic [15:0] data;
        logic        ior_n;
        logic        iow_n;
        logic        sbhe_n;
        logic        aen;
    } isatc_bus_type;

    typedef struct packed {
        logic       ref_clk;
        logic       rate_link;
        logic [3:0] irq_code;
        logic [9:0] sw;
    } isatc_pin_type;

    typedef struct packed {
        logic [6:0] rsv_hi;
        logic       open_pll;
        logic       cfg_lock;
        logic       use_buf;
        logic       bank;
        logic       stop;
        logic       free_drive;
        logic       x10;
        logic       rsv_go;
        logic       dir;
    } isatc_ctl_type;

    typedef struct packed {
        logic slide_go;
        logic sn_reset;
        logic sn_clk;
    } isatc_pulse_type;

    typedef struct packed {
        logic        vld;
        logic [1:0]  word;
        logic [1:0]  be;
        logic [15:0] data;
    } isatc_tw_type;

    function automatic logic isatc_irq_ok(input logic [3:0] c);
        return c inside {4'h5, 4'hA, 4'hB, 4'hC, 4'hD};
    endfunction : isatc_irq_ok

    function automatic logic [15:0] isatc_merge(input logic [15:0] o,
                                                input logic [15:0] d,
                                                input logic [1:0]  be);
        logic [15:0] m;
        m = {{8{be[1]}}, {8{be[0]}}};
        return (o & ~m) | (d & m);
    endfunction : isatc_merge

endpackage : isatc_pkg

// >>> isatc_regs.sv
`timescale 1ns/100ps
// Function
// RULE1 - window of 32 sixteen-bit I/O locations
// RULE2 - base from 10-bit switch, upper address
// RULE3 - full 16-bit decode, no aliases
// RULE4 - default base address is 0x2300
// RULE5 - pointer, data, control, enables, flags offsets
// RULE6 - absolute time four words, low first
// RULE7 - tick phase 24 bits in two words
// RULE8 - uptime two words, latency at 0x1A
// RULE9 - six interrupt sources including self request; the code has seven (ms, sec, self, pll, ext, tv, qms)
// RULE10 - per-source enables plus one master enable
// RULE11 - irq line from 4-bit binary link code
// RULE12 - unsupported link code drives no line
// RULE13 - rate link open 10MHz, fitted 5MHz
// RULE14 - reader skips ones, zero, seven bits
// RULE15 - characters eight bits, lsb first
// RULE16 - reader stops at zero character
// RULE17 - reference lost after 1us without edge
// RULE18 - free run: detector off, bias on
// RULE19 - pointer increments after data port access
// RULE20 - pointer is 8-bit read/write index
// RULE21 - frame buffer 64 words at 0x00
// RULE22 - config memory 0x40, aliased to 0x7f
// RULE23 - phase counters 0x80, aliased to 0xbf
// RULE24 - host excludes others during block transfer
// RULE25 - advance only on word or high byte
// RULE26 - bank is bank bit xor frame lsb
// RULE27 - status read clears flags, drops line
// RULE28 - unmapped offsets read zero, ignore writes
module isatc_regs (
    // system
    input  wire  logic                    clk,
    input  wire  logic                    srst,
    // isa bus pins
    input  wire  logic [15:0]             sa,
    input  wire  logic [15:0]             sd_in,
    output logic       [15:0]             sd_out,
    output logic                          sd_oe,
    input  wire  logic                    ior_n,
    input  wire  logic                    iow_n,
    input  wire  logic                    sbhe_n,
    input  wire  logic                    aen,
    output logic       [15:0]             irq_out,
    // board straps
    input  wire  logic [9:0]              base_switch,
    input  wire  logic                    reference_rate_link,
    input  wire  logic                    irq_code_link_a,
    input  wire  logic                    irq_code_link_b,
    input  wire  logic                    irq_code_link_c,
    input  wire  logic                    irq_code_link_d,
    // reference and oscillator
    input  wire  logic                    ref_in,
    output logic                          ref_rate_10m,
    output logic                          ref_lost,
    output logic                          pd_oe,
    output logic                          bias_oe,
    // timing core
    input  wire  logic [63:0]             abs_time,
    input  wire  logic [23:0]             tick_phase,
    input  wire  logic [23:0]             uptime,
    input  wire  logic [15:0]             irq_latency,
    input  wire  logic [15:0][15:0]       supp_phase,
    input  wire  logic                    timebase_50m,
    input  wire  logic                    sliding,
    input  wire  logic                    running,
    input  wire  logic                    pll_locked,
    input  wire  logic                    frame_lsb,
    input  wire  logic                    ms_tick,
    input  wire  logic                    sec_tick,
    input  wire  logic                    ext_tick,
    input  wire  logic                    tick_valid,
    input  wire  logic                    qms_tick,
    output isatc_pkg::isatc_ctl_type      ctl_out,
    output isatc_pkg::isatc_pulse_type    pulse_out,
    output isatc_pkg::isatc_tw_type       time_wr,
    // framer read port
    input  wire  logic [6:0]              frame_rd_addr,
    output logic       [15:0]             frame_rd_data
);

    // ****************************************
    // state
    // ****************************************
    typedef struct packed {
        isatc_pkg::isatc_bus_type   bus_m;
        isatc_pkg::isatc_bus_type   bus_s;
        isatc_pkg::isatc_bus_type   acc;
        isatc_pkg::isatc_pin_type   pin_m;
        isatc_pkg::isatc_pin_type   pin_s;
        logic                       ref_d;
        logic [9:0]                 base;
        logic [7:0]                 ptr;
        isatc_pkg::isatc_ctl_type   ctl;
        logic [15:0]                ien;
        logic [6:0]                 iflag;
        logic                       frame_x;
        logic                       pll_d;
        logic                       tv_d;
        logic [7:0]                 loss_cnt;
        logic                       lost;
        logic                       rd_d;
        logic                       wr_d;
        logic [15:0]                sd_out;
        logic                       sd_oe;
        logic [15:0]                irq;
        logic                       ref10;
        logic                       pd_oe;
        logic                       bias_oe;
        isatc_pkg::isatc_pulse_type pulse;
        isatc_pkg::isatc_tw_type    tw;
        logic [15:0]                frd;
        logic [127:0][15:0]         fbuf;
        logic [15:0][15:0]          cfg;
    } isatc_state_type;
    isatc_state_type q_r;
    isatc_state_type q_nxt;

    // ****************************************
    // bus decode
    // ****************************************
    function automatic logic [1:0] lanes(input isatc_pkg::isatc_bus_type b);
        return b.addr[0] ? 2'b10 : (b.sbhe_n ? 2'b01 : 2'b11);
    endfunction : lanes

    function automatic logic [15:0] wdata(input isatc_pkg::isatc_bus_type b);
        return (b.addr[0] && b.sbhe_n) ? {b.data[7:0], b.data[7:0]} : b.data;
    endfunction : wdata

    function automatic logic [5:0] woff(input isatc_pkg::isatc_bus_type b);
        return {b.addr[5:1], 1'b0};
    endfunction : woff
    logic        hit;
    logic        rd_act;
    logic        wr_act;
    logic        rd_start;
    logic        rd_end;
    logic        wr_end;
    logic [5:0]  r_off;
    logic [1:0]  r_be;
    logic [5:0]  a_off;
    logic [1:0]  a_be;
    logic [15:0] a_wd;
    logic        bank;
    logic        ref_edge;

    assign hit      = (q_r.bus_s.addr[15:6] == q_r.base) && !q_r.bus_s.aen; // see RULE2 see RULE3
    assign rd_act   = hit && !q_r.bus_s.ior_n;
    assign wr_act   = hit && !q_r.bus_s.iow_n;
    assign rd_start = rd_act && !q_r.rd_d;
    assign rd_end   = !rd_act && q_r.rd_d;
    assign wr_end   = !wr_act && q_r.wr_d;
    assign r_off    = woff(q_r.bus_s); // see RULE1
    assign r_be     = lanes(q_r.bus_s);
    assign a_off    = woff(q_r.acc);
    assign a_be     = lanes(q_r.acc);
    assign a_wd     = wdata(q_r.acc);
    assign bank     = q_r.ctl.bank ^ frame_lsb; // see RULE26
    assign ref_edge = q_r.pin_s.ref_clk && !q_r.ref_d;

    // ****************************************
    // next state
    // ****************************************
    logic [15:0] rdv;
    logic [15:0] memrd;
    logic [15:0] g;
    logic [6:0]  ev;
    logic        self_req;
    logic        xclr;
    logic        irq_on;

    always_comb begin
        q_nxt    = q_r;
        memrd    = 16'h0000;
        rdv      = 16'h0000;
        g        = 16'h0000;
        self_req = 1'b0;
        xclr     = 1'b0;
        q_nxt.bus_m = '{addr: sa, data: sd_in, ior_n: ior_n, iow_n: iow_n,
                        sbhe_n: sbhe_n, aen: aen};
        q_nxt.bus_s = q_r.bus_m;
        q_nxt.pin_m = '{ref_clk: ref_in, rate_link: reference_rate_link,
                        irq_code: {irq_code_link_a, irq_code_link_b,
                                   irq_code_link_c, irq_code_link_d},
                        sw: base_switch};
        q_nxt.pin_s = q_r.pin_m;
        q_nxt.ref_d = q_r.pin_s.ref_clk;
        q_nxt.base  = q_r.pin_s.sw; // see RULE2
        q_nxt.rd_d  = rd_act;
        q_nxt.wr_d  = wr_act;
        q_nxt.pulse = '0;
        q_nxt.tw    = '0;
        if (rd_act || wr_act) begin
            q_nxt.acc = q_r.bus_s;
        end

        // internal memory read at the pointer
        if (q_r.ptr < isatc_pkg::MEM_CFG) begin
            memrd = q_r.fbuf[{bank, q_r.ptr[5:0]}]; // see RULE21 see RULE20
        end else if (q_r.ptr < isatc_pkg::MEM_SUP) begin
            memrd = q_r.cfg[q_r.ptr[3:0]]; // see RULE22
        end else if (q_r.ptr < isatc_pkg::MEM_END) begin
            memrd = supp_phase[q_r.ptr[3:0]]; // see RULE23
        end

        // register read mux
        case (r_off) // see RULE5
            isatc_pkg::OFF_PTR:  rdv = {8'h00, q_r.ptr};
            isatc_pkg::OFF_DATA: rdv = memrd;
            isatc_pkg::OFF_CTL:  rdv = {pll_locked, running, q_r.frame_x, sliding,
                                        2'b00, timebase_50m, 1'b0, q_r.ctl[7:0]};
            isatc_pkg::OFF_IEN:  rdv = q_r.ien;
            isatc_pkg::OFF_IFL:  rdv = {9'h000, q_r.iflag};
            isatc_pkg::OFF_AT0:  rdv = abs_time[15:0]; // see RULE6
            isatc_pkg::OFF_AT1:  rdv = abs_time[31:16];
            isatc_pkg::OFF_AT2:  rdv = abs_time[47:32];
            isatc_pkg::OFF_AT3:  rdv = abs_time[63:48];
            isatc_pkg::OFF_PHL:  rdv = tick_phase[15:0]; // see RULE7
            isatc_pkg::OFF_PHH:  rdv = {8'h00, tick_phase[23:16]};
            isatc_pkg::OFF_UPL:  rdv = uptime[15:0]; // see RULE8
            isatc_pkg::OFF_UPH:  rdv = {8'h00, uptime[23:16]};
            isatc_pkg::OFF_LAT:  rdv = irq_latency;
            default:             rdv = 16'h0000; // see RULE28
        endcase
        if (rd_start) begin
            q_nxt.sd_out = (r_be == 2'b10) ? {rdv[15:8], rdv[15:8]} : rdv;
        end
        q_nxt.sd_oe = rd_act;

        // ****************************************
        // write commit at the end of the strobe
        // ****************************************
        if (wr_end) begin
            case (a_off)
                isatc_pkg::OFF_PTR: begin
                    if (a_be[0]) begin
                        q_nxt.ptr = a_wd[7:0]; // see RULE20
                    end
                end
                isatc_pkg::OFF_DATA: begin
                    if (q_r.ptr < isatc_pkg::MEM_CFG) begin
                        q_nxt.fbuf[{bank, q_r.ptr[5:0]}] =
                            isatc_pkg::isatc_merge(q_r.fbuf[{bank, q_r.ptr[5:0]}],
                                                   a_wd, a_be); // see RULE21
                    end else if (q_r.ptr < isatc_pkg::MEM_SUP && !q_r.ctl.cfg_lock) begin
                        q_nxt.cfg[q_r.ptr[3:0]] =
                            isatc_pkg::isatc_merge(q_r.cfg[q_r.ptr[3:0]],
                                                   a_wd, a_be); // see RULE22
                    end
                end
                isatc_pkg::OFF_CTL: begin
                    q_nxt.ctl = isatc_pkg::isatc_ctl_type'(isatc_pkg::isatc_merge(
                        q_r.ctl, a_wd, a_be) & isatc_pkg::CTL_STORE);
                    g = isatc_pkg::isatc_merge(16'h0000, a_wd, a_be);
                    q_nxt.pulse.slide_go = g[isatc_pkg::C_GO];
                    q_nxt.pulse.sn_reset = g[isatc_pkg::C_SNRST];
                    q_nxt.pulse.sn_clk   = g[isatc_pkg::C_SNCLK];
                    self_req             = g[isatc_pkg::C_SELF];
                    xclr                 = g[isatc_pkg::C_XCLR];
                end
                isatc_pkg::OFF_IEN: begin
                    q_nxt.ien = isatc_pkg::isatc_merge(q_r.ien, a_wd, a_be) &
                                isatc_pkg::IEN_STORE; // see RULE10
                end
                isatc_pkg::OFF_AT0, isatc_pkg::OFF_AT1,
                isatc_pkg::OFF_AT2, isatc_pkg::OFF_AT3: begin
                    q_nxt.tw = '{vld: 1'b1, word: 2'(a_off[5:1] - 5'h05),
                                 be: a_be, data: a_wd}; // see RULE6
                end
                default: begin
                    q_nxt.tw = '0; // see RULE28
                end
            endcase
        end

        // pointer advance after a word or the high byte
        if ((rd_end || wr_end) && a_off == isatc_pkg::OFF_DATA && a_be[1]) begin
            q_nxt.ptr = q_r.ptr + 8'h01; // see RULE19 see RULE25
        end

        // ****************************************
        // interrupts
        // ****************************************
        ev                  = '0;
        ev[isatc_pkg::I_MS]   = ms_tick; // see RULE9
        ev[isatc_pkg::I_SEC]  = sec_tick;
        ev[isatc_pkg::I_SELF] = self_req;
        ev[isatc_pkg::I_PLL]  = pll_locked ^ q_r.pll_d;
        ev[isatc_pkg::I_EXT]  = ext_tick;
        ev[isatc_pkg::I_TV]   = tick_valid ^ q_r.tv_d;
        ev[isatc_pkg::I_QMS]  = qms_tick;
        q_nxt.pll_d = pll_locked;
        q_nxt.tv_d  = tick_valid;
        // a new event in the clearing cycle survives
        q_nxt.iflag = ((rd_start && r_off == isatc_pkg::OFF_IFL) ? 7'h00 : q_r.iflag)
                      | ev; // see RULE27
        irq_on = q_nxt.ien[isatc_pkg::I_MASTER] &&
                 |(q_nxt.iflag & q_nxt.ien[6:0]); // see RULE10
        if (irq_on && isatc_pkg::isatc_irq_ok(q_r.pin_s.irq_code)) begin
            q_nxt.irq = 16'h0001 << q_r.pin_s.irq_code; // see RULE11
        end else begin
            q_nxt.irq = 16'h0000; // see RULE12
        end
        q_nxt.frame_x = (xclr ? 1'b0 : q_r.frame_x) | ms_tick;

        // ****************************************
        // reference loss and free run
        // ****************************************
        if (ref_edge) begin
            q_nxt.loss_cnt = 8'h00;
        end else if (q_r.loss_cnt != isatc_pkg::REF_LOSS_CYC) begin
            q_nxt.loss_cnt = q_r.loss_cnt + 8'h01;
        end
        q_nxt.lost    = (q_nxt.loss_cnt == isatc_pkg::REF_LOSS_CYC); // see RULE17
        q_nxt.pd_oe   = !(q_nxt.lost || q_nxt.ctl.open_pll); // see RULE18
        q_nxt.bias_oe = q_nxt.lost || q_nxt.ctl.open_pll;
        q_nxt.ref10   = q_r.pin_s.rate_link; // see RULE13
        q_nxt.frd     = q_r.fbuf[frame_rd_addr];
    end

    // ****************************************
    // registers
    // ****************************************
    always_ff @(posedge clk) begin
        if (srst) begin
            q_r              <= '0;
            q_r.bus_m.ior_n  <= 1'b1;
            q_r.bus_m.iow_n  <= 1'b1;
            q_r.bus_m.aen    <= 1'b1;
            q_r.bus_s.ior_n  <= 1'b1;
            q_r.bus_s.iow_n  <= 1'b1;
            q_r.bus_s.aen    <= 1'b1;
            q_r.pin_m.sw     <= isatc_pkg::BASE_DEFAULT;
            q_r.pin_s.sw     <= isatc_pkg::BASE_DEFAULT;
            q_r.base         <= isatc_pkg::BASE_DEFAULT; // see RULE4
            q_r.ptr          <= isatc_pkg::PTR_RST;
            q_r.ctl          <= isatc_pkg::isatc_ctl_type'(isatc_pkg::CTL_RST);
            q_r.ien          <= isatc_pkg::IEN_RST;
            q_r.pd_oe        <= 1'b1;
        end else begin
            q_r <= q_nxt;
        end
    end

    assign sd_out        = q_r.sd_out;
    assign sd_oe         = q_r.sd_oe;
    assign irq_out       = q_r.irq;
    assign ref_rate_10m  = q_r.ref10;
    assign ref_lost      = q_r.lost;
    assign pd_oe         = q_r.pd_oe;
    assign bias_oe       = q_r.bias_oe;
    assign ctl_out       = q_r.ctl;
    assign pulse_out     = q_r.pulse;
    assign time_wr       = q_r.tw;
    assign frame_rd_data = q_r.frd;

    // ****************************************
    // checks
    // ****************************************
    window_hit_a : assert property (@(posedge clk) disable iff (srst) // see RULE3
        $rose(sd_oe) |-> $past(q_r.bus_s.addr[15:6]) == $past(q_r.base))
        else $error("read answered outside the window");
    unmapped_zero_a : assert property (@(posedge clk) disable iff (srst) // see RULE28
        (rd_start && r_off > isatc_pkg::OFF_LAT) |=> sd_out == 16'h0000)
        else $error("unmapped offset read not zero");
    status_clear_a : assert property (@(posedge clk) disable iff (srst) // see RULE27
        (rd_start && r_off == isatc_pkg::OFF_IFL && !ms_tick && !sec_tick
         && !ext_tick && !qms_tick && pll_locked == q_r.pll_d
         && tick_valid == q_r.tv_d && !wr_end) |=> (irq_out == 16'h0000))
        else $error("status read did not drop the line");
    irq_line_a : assert property (@(posedge clk) disable iff (srst) // see RULE11
        (irq_out != 16'h0000) |-> $onehot(irq_out) &&
        (irq_out & 16'h3C20) == irq_out)
        else $error("interrupt on unsupported line");
    irq_none_a : assert property (@(posedge clk) disable iff (srst) // see RULE12
        !isatc_pkg::isatc_irq_ok(q_r.pin_s.irq_code) |=> irq_out == 16'h0000)
        else $error("line driven for unsupported code");
    master_gate_a : assert property (@(posedge clk) disable iff (srst) // see RULE10
        !q_r.ien[isatc_pkg::I_MASTER] |-> irq_out == 16'h0000)
        else $error("interrupt with master disabled");
    ref_loss_a : assert property (@(posedge clk) disable iff (srst) // see RULE17
        $rose(ref_lost) |-> $past(q_r.loss_cnt) == isatc_pkg::REF_LOSS_CYC - 8'h01
        && !$past(ref_edge))
        else $error("reference declared lost early");
    ref_back_a : assert property (@(posedge clk) disable iff (srst) // see RULE17
        ref_edge |=> !ref_lost [*2])
        else $error("reference edge did not clear loss");
    free_run_a : assert property (@(posedge clk) disable iff (srst) // see RULE18
        ref_lost |-> !pd_oe && bias_oe)
        else $error("free run drivers wrong");
    ptr_inc_a : assert property (@(posedge clk) disable iff (srst) // see RULE19
        ((rd_end || wr_end) && a_off == isatc_pkg::OFF_DATA && a_be[1])
        |=> q_r.ptr == $past(q_r.ptr) + 8'h01)
        else $error("pointer did not advance");
    ptr_hold_a : assert property (@(posedge clk) disable iff (srst) // see RULE25
        ((rd_end || wr_end) && a_off == isatc_pkg::OFF_DATA && !a_be[1])
        |=> $stable(q_r.ptr))
        else $error("pointer advanced on low byte");

endmodule : isatc_regs

// >>> isatc_host.sv
`timescale 1ns/100ps
module isatc_host (
    // bus
    input  wire logic                clk,
    input  wire logic [15:0]         sd_out,
    input  wire logic                sd_oe,
    output isatc_pkg::isatc_bus_type bus
);
    initial bus = {16'h0000, 16'h0000, 1'b1, 1'b1, 1'b0, 1'b0};
    // ****************************************
    // one i/o cycle: strobe low 4 clocks, high 6
    // ****************************************
    task automatic io(input logic wr, input logic [15:0] a, d, input logic bhe_n,
                      output logic [15:0] q);
        @(posedge clk);
        bus.addr   <= a;
        bus.data   <= d;
        bus.sbhe_n <= bhe_n;
        bus.iow_n  <= ~wr;
        bus.ior_n  <= wr;
        repeat (4) @(posedge clk);
        q = sd_oe ? sd_out : 16'hFFFF;
        bus.ior_n <= 1'b1;
        bus.iow_n <= 1'b1;
        bus.data  <= ~d;
        repeat (6) @(posedge clk);
    endtask : io
endmodule : isatc_host

// >>> isatc_regs_bench.sv
`timescale 1ns/100ps
module isatc_regs_bench;
    isatc_pkg::isatc_bus_type   bus;
    isatc_pkg::isatc_ctl_type   ctl_out;
    isatc_pkg::isatc_pulse_type pulse_out;
    isatc_pkg::isatc_tw_type    time_wr;
    logic clk = 1'b0, srst = 1'b1, ref_in = 1'b0, ref_go = 1'b0, frame_lsb = 1'b0;
    logic ior_n, iow_n, sbhe_n, aen, sd_oe, ref_rate_10m, ref_lost, pd_oe, bias_oe;
    logic irq_code_link_a, irq_code_link_b, irq_code_link_c, irq_code_link_d;
    logic timebase_50m, sliding, running, pll_locked, tick_valid;
    logic ms_tick, sec_tick, ext_tick, qms_tick, reference_rate_link = 1'b1;
    logic [15:0] sa, sd_in, sd_out, irq_out, frame_rd_data, q, cnt = 16'h0000;
    logic [15:0] irq_latency = 16'h5A3C;
    logic [15:0][15:0] supp_phase;
    logic [63:0] abs_time = 64'h0123_4567_89AB_CDEF;
    logic [23:0] tick_phase = 24'hA5C3E1, uptime = 24'h3C5A69;
    logic [9:0] base_switch = isatc_pkg::BASE_DEFAULT;
    logic [6:0] frame_rd_addr = 7'h3E;
    logic [7:0] sn_cnt = 8'hFF;
    logic [3:0] code = 4'hA;
    int num_errors = 0, num_checks = 0, n = 0;
    assign {sa, sd_in, ior_n, iow_n, sbhe_n, aen} = bus;
    assign {irq_code_link_a, irq_code_link_b, irq_code_link_c, irq_code_link_d} = code;
    assign {pll_locked, running, sliding, timebase_50m, tick_valid} = cnt[15:11];
    assign {ms_tick, sec_tick, ext_tick, qms_tick} = {4{cnt[9:0] == 10'h3FF}};
    initial forever #4 clk = ~clk;
    always @(posedge clk) cnt <= cnt + 16'h0001;
    always @(posedge clk) ref_in <= ref_go ? ~ref_in : ref_in;
    always @(posedge clk) sn_cnt <= pulse_out.sn_reset ? 8'h00 : sn_cnt + 8'(pulse_out.sn_clk);
    isatc_regs i_dut (.*);
    isatc_host i_host (.clk(clk), .sd_out(sd_out), .sd_oe(sd_oe), .bus(bus));
    task automatic chk(input string s, input logic [15:0] e, g);
        num_checks++;
        if (g !== e) begin
            $display("unexpected %s: expected %h seen %h", s, e, g);
            num_errors++;
        end
    endtask : chk
    task automatic wr(input logic [15:0] a, d, input logic bhe_n = 1'b0);
        i_host.io(1'b1, a, d, bhe_n, q);
    endtask : wr
    task automatic rc(input logic [15:0] a, e);
        i_host.io(1'b0, a, 16'h0000, 1'b0, q);
        chk($sformatf("read %h", a), e, q);
    endtask : rc
    task automatic t_regs;
        rc(16'h2300, 16'h0000);
        rc(16'h2306, 16'h0000);
        wr(16'h2306, 16'h0041);
        rc(16'h2306, 16'h0041);
        wr(16'h0306, 16'h0002);
        rc(16'h2306, 16'h0041);
        wr(16'h231C, 16'hFFFF);
        rc(16'h231C, 16'h0000);
        for (int i = 0; i < 4; i++) rc(16'h230A + 16'(2 * i), abs_time[16 * i +: 16]);
        rc(16'h231A, irq_latency);
        rc(16'h2312, 16'hC3E1);
        rc(16'h2314, 16'h00A5);
        rc(16'h2316, 16'h5A69);
        rc(16'h2318, 16'h003C);
        $display("register test done");
    endtask : t_regs
    task automatic t_buf;
        wr(16'h2300, 16'h003E);
        wr(16'h2302, 16'h1111);
        wr(16'h2302, 16'h0022, 1'b1);
        rc(16'h2300, 16'h003F);
        wr(16'h2303, 16'h2200);
        rc(16'h2300, 16'h0040);
        wr(16'h2302, 16'hABCD);
        wr(16'h2300, 16'h003E);
        rc(16'h2302, 16'h1111);
        rc(16'h2302, 16'h2222);
        chk("frame read", 16'h1111, frame_rd_data);
        frame_lsb <= 1'b1;
        wr(16'h2300, 16'h003E);
        rc(16'h2302, 16'h0000);
        frame_lsb <= 1'b0;
        wr(16'h2300, 16'h0070);
        rc(16'h2302, 16'hABCD);
        wr(16'h2300, 16'h00B3);
        rc(16'h2302, supp_phase[3]);
        $display("buffer test done");
    endtask : t_buf
    task automatic t_irq;
        wr(16'h2306, 16'h8004);
        wr(16'h2304, 16'h1000);
        chk("irq line", 16'h0400, irq_out);
        i_host.io(1'b0, 16'h2308, 16'h0000, 1'b0, q);
        chk("self flag", 16'h0004, q & 16'h0004);
        chk("irq line", 16'h0000, irq_out);
        wr(16'h2306, 16'h0004);
        wr(16'h2304, 16'h1000);
        chk("irq line", 16'h0000, irq_out);
        code <= 4'h3;
        wr(16'h2306, 16'h8004);
        wr(16'h2304, 16'h1000);
        chk("irq line", 16'h0000, irq_out);
        $display("interrupt test done");
    endtask : t_irq
    task automatic t_sn;
        wr(16'h2304, 16'h02C0);
        chk("control", 16'h00C0, ctl_out);
        for (int i = 0; i < 8; i++) wr(16'h2304, 16'h0400);
        chk("prom clocks", 16'h0008, 16'(sn_cnt));
        $display("serial test done");
    endtask : t_sn
    task automatic t_ref;
        chk("rate", 16'h0001, 16'(ref_rate_10m));
        reference_rate_link <= 1'b0;
        ref_go <= 1'b1;
        repeat (40) @(posedge clk);
        chk("rate", 16'h0000, 16'(ref_rate_10m));
        chk("detector on", 16'h0001, 16'(pd_oe));
        ref_go <= 1'b0;
        while (ref_lost !== 1'b1 && n < 400) begin
            @(posedge clk);
            n++;
        end
        chk("loss time", 16'h0001, 16'(n >= isatc_pkg::REF_LOSS_I - 2 && n < 140));
        if (n >= 400) results();
        @(posedge clk);
        chk("detector off", 16'h0000, 16'(pd_oe));
        chk("bias on", 16'h0001, 16'(bias_oe));
        $display("reference test done");
    endtask : t_ref
    task automatic results;
        $display("checks %0d mismatches %0d", num_checks, num_errors);
        if (num_errors == 0 && num_checks > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask : results
    initial begin
        foreach (supp_phase[i]) supp_phase[i] = 16'h1000 + 16'(i);
        repeat (10) @(posedge clk);
        srst <= 1'b0;
        t_regs();
        t_buf();
        t_irq();
        t_sn();
        t_ref();
        results();
    end
endmodule : isatc_regs_bench
